/* test/conv_model.sv */
// Converter stand-in: answers each convStart after lat+1 idle cycles.
// Assumes the sequencer's clock; remote samples alternate code, code+1.
`timescale 1ns/100ps
module conv_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic convStart,
   input wire logic [3:0] convChan,
   input wire logic convRemote,
   input wire logic [7:0] lat,
   input wire logic [9:0][7:0] code,
   input wire logic [1:0] frac,
   output logic convValid,
   output logic [9:0] convData
);
   logic [7:0] cnt;
   logic busy;
   logic odd;
   // Latency count, then one valid pulse; data inverts on every cycle outside that pulse
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= 8'h00;
         busy <= 1'b0;
         odd <= 1'b0;
         convValid <= 1'b0;
         convData <= 10'h155;
      end else begin
         convValid <= 1'b0;
         convData <= ~convData;
         if (convStart) begin
            busy <= 1'b1;
            cnt <= lat;
         end else if (busy && cnt == 8'h00) begin
            busy <= 1'b0;
            convValid <= 1'b1;
            convData <= {code[convChan] + {7'h00, convRemote & odd}, frac};
            odd <= odd ^ convRemote;
         end else if (busy) begin
            cnt <= cnt - 8'h01;
         end
      end
   end
endmodule // conv_model

/* test/monitor_cycle_temp_sequencer_test.sv */
// Self-checking bench: Wishbone register access plus converter model.
// Assumes short slot parameters so a full loop is a few hundred cycles.
`timescale 1ns/100ps
module monitor_cycle_temp_sequencer_test;
   logic clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
   logic [3:0] wb_sel_i, convChan;
   logic convStart, convRemote, convValid, intN, fanRun;
   logic [9:0] convData;
   logic [7:0] lat;
   logic [9:0][7:0] code;
   logic [1:0] frac;
   int fails, nChecks;
   // Short analog slot so a loop fits the run
   localparam int SLOT_A = 20;
   monitor_cycle_temp_sequencer #(.SLOT_ANALOG_CYCLES(SLOT_A),
      .SLOT_REMOTE_CYCLES(40)) i_dut (.clk(clk), .reset_n(reset_n),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .convStart(convStart),
      .convChan(convChan), .convRemote(convRemote), .convValid(convValid),
      .convData(convData), .intN(intN), .fanRun(fanRun));
   conv_model i_conv (.clk(clk), .reset_n(reset_n), .convStart(convStart),
      .convChan(convChan), .convRemote(convRemote), .lat(lat),
      .code(code), .frac(frac), .convValid(convValid),
      .convData(convData));
   // Free-running 125 MHz clock
   always #4 clk = ~clk;
   task end_sim();
      $display("checks %0d mismatches %0d", nChecks, fails);
      if (fails == 0 && nChecks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      nChecks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One classic cycle, held until ack is sampled high
   task wb(input logic we, input logic [7:0] idx, input logic [7:0] wd,
           output logic [7:0] rd);
      int k;
      k = 0;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {22'h000000, idx, 2'b00};
      wb_dat_i <= {24'h000000, wd};
      wb_sel_i <= 4'h1;
      @(posedge clk);
      while (wb_ack_o !== 1'b1 && k < 20) begin
         @(posedge clk);
         k++;
      end
      rd = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (k >= 20) begin
         cmp("ack", 1, 0);
         end_sim();
      end
   endtask
   task wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] x;
      wb(1'b1, idx, d, x);
   endtask
   task rd(input logic [7:0] idx, input logic [7:0] e);
      logic [7:0] x;
      wb(1'b0, idx, 8'h00, x);
      cmp($sformatf("reg %h", idx), {24'h0, e}, {24'h0, x});
   endtask
   // Bounded wait for the start of a conversion on channel ch
   task wait_ch(input logic [3:0] ch);
      int k;
      k = 0;
      @(posedge clk);
      while (!(convStart === 1'b1 && convChan === ch) && k < 4000) begin
         @(posedge clk);
         k++;
      end
      if (k >= 4000) begin
         cmp("wait_ch", {28'h0, ch}, 32'hffffffff);
         end_sim();
      end
   endtask
   task loop2();
      wait_ch(4'h0);
      wait_ch(4'h0);
   endtask
   task t_reset();
      cmp("intN", 1, {31'h0, intN});
      cmp("fanRun", 0, {31'h0, fanRun});
      rd(8'h40, 8'h00);
      rd(8'h47, 8'h00);
      rd(8'h50, 8'hff);
      rd(8'h60, 8'h00);
      rd(8'h57, 8'h7f);
      rd(8'h67, 8'h80);
      rd(8'h41, 8'h00);
      rd(8'h30, 8'h00);
      $display("t_reset done");
   endtask
   task t_run();
      realtime t0;
      wr(8'h40, 8'h03);
      wait_ch(4'h0);
      t0 = $realtime;
      wait_ch(4'h1);
      cmp("slot", SLOT_A, int'(($realtime - t0) / 8));
      cmp("fanRun", 1, {31'h0, fanRun});
      wait_ch(4'h0);
      for (int i = 0; i < 10; i++) begin
         rd(8'h20 + 8'(i), code[i]);
      end
      rd(8'h4b, 8'h40);
      wr(8'h4b, 8'hff);
      rd(8'h4b, 8'h7f);
      wr(8'h20, 8'h99);
      rd(8'h20, 8'h10);
      rd(8'h41, 8'h00);
      cmp("intN", 1, {31'h0, intN});
      $display("t_run done");
   endtask
   task t_limits();
      wr(8'h52, 8'h3f);
      wr(8'h63, 8'h51);
      loop2();
      rd(8'h41, 8'h0c);
      cmp("intN", 0, {31'h0, intN});
      wr(8'h52, 8'hff);
      wr(8'h63, 8'h00);
      wr(8'h40, 8'h0b);
      rd(8'h41, 8'h00);
      cmp("intN", 1, {31'h0, intN});
      wr(8'h52, 8'h3f);
      wr(8'h40, 8'h01);
      loop2();
      rd(8'h41, 8'h04);
      cmp("intN", 1, {31'h0, intN});
      wr(8'h40, 8'h03);
      rd(8'h41, 8'h04);
      cmp("intN", 0, {31'h0, intN});
      wr(8'h52, 8'hff);
      wr(8'h40, 8'h0b);
      rd(8'h41, 8'h00);
      cmp("intN", 1, {31'h0, intN});
      $display("t_limits done");
   endtask
   task t_hot();
      wr(8'h57, 8'h18);
      loop2();
      rd(8'h41, 8'h80);
      wr(8'h57, 8'h30);
      wr(8'h40, 8'h0b);
      loop2();
      rd(8'h41, 8'h80);
      wr(8'h67, 8'h1a);
      loop2();
      wr(8'h40, 8'h0b);
      loop2();
      rd(8'h41, 8'h00);
      cmp("intN", 1, {31'h0, intN});
      wr(8'h57, 8'h7f);
      wr(8'h67, 8'h80);
      $display("t_hot done");
   endtask
   task t_mode();
      wait_ch(4'h7);
      cmp("remote7", 0, {31'h0, convRemote});
      wait_ch(4'h8);
      cmp("remote8", 1, {31'h0, convRemote});
      code[9] <= 8'h9c;
      wr(8'h47, 8'h04);
      wait_ch(4'h9);
      cmp("remote9", 1, {31'h0, convRemote});
      wait_ch(4'h0);
      rd(8'h29, 8'h9c);
      code[9] <= 8'h9d;
      lat <= 8'd40;
      loop2();
      rd(8'h29, 8'h9d);
      rd(8'h28, 8'he7);
      $display("t_mode done");
   endtask
   task t_halt();
      int n;
      n = 0;
      wr(8'h40, 8'h00);
      repeat (200) begin
         @(posedge clk);
         n += int'(convStart === 1'b1);
      end
      cmp("starts", 0, n);
      cmp("fanRun", 0, {31'h0, fanRun});
      $display("t_halt done");
   endtask
   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 32'h00000000;
      wb_dat_i = 32'h00000000;
      wb_sel_i = 4'h0;
      lat = 8'd2;
      frac = 2'b01;
      code = {8'h64, 8'he7, 8'h19, 8'h01, 8'hf5, 8'hc0, 8'h50, 8'h40,
              8'h20, 8'h10};
      fails = 0;
      nChecks = 0;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_run();
      t_limits();
      t_hot();
      t_mode();
      t_halt();
      end_sim();
   end
endmodule // monitor_cycle_temp_sequencer_test

/* verilog/limit_check.sv */
// Limit comparison of one fresh result against its channel's limits.
// Assumes the caller supplies the channel kind and its hot state.
`timescale 1ns/100ps
module limit_check (
   mon_if.chkSide port
);
   // Signed compare for temperatures, unsigned for voltage codes
   always_comb begin
      if (port.isTemp) begin
         port.over = $signed(port.result) > $signed(port.high);
         port.under = $signed(port.result) < $signed(port.low);
      end else begin
         port.over = port.result > port.high;
         port.under = port.result < port.low;
      end
      if (port.over) begin
         port.hotOut = 1'b1;
      end else if (port.under) begin
         port.hotOut = 1'b0;
      end else begin
         port.hotOut = port.hotIn;
      end
   end
endmodule // limit_check

/* verilog/mon_if.sv */
// Carrier between the sequencer core, its value memory and limit checker.
// Assumes all three sit on one clock.
`timescale 1ns/100ps
interface mon_if;
   logic wrEn;
   logic [3:0] wrAddr;
   logic [7:0] wrData;
   logic [3:0] rdAddr;
   logic [7:0] rdData;
   logic [7:0] result;
   logic [7:0] high;
   logic [7:0] low;
   logic isTemp;
   logic hotIn;
   logic over;
   logic under;
   logic hotOut;
   modport memSide(input wrEn, wrAddr, wrData, rdAddr, output rdData);
   modport chkSide(input result, high, low, isTemp, hotIn,
                   output over, under, hotOut);
endinterface // mon_if

/* verilog/mon_pkg.sv */
// Constants, register indices and state codes of the monitor sequencer.
// Assumes a 125 MHz clock and a Wishbone register bus with 32-bit words.
// Operation
// - Local sensor integer goes to its value register, fraction to bits 7:6.
// - Temperatures are 8-bit two's complement, -128 to +127, one degree.
// - Plain two's complement, fraction truncated, so +0.5 reads zero.
// - Remote channel one always temperature; shared pair only when mode bit 2.
// - Each remote result averages 16 conversions.
// - Voltage above high or below low limit raises an event.
// - Temperature hot state sets above hot limit, clears below hysteresis.
// - Writing start one with clear zero starts monitoring.
// - Each configured input converted in turn, result stored on completion.
// - Loop repeats until software writes start bit zero.
// - Value registers readable anytime, holding the latest result.
// - Loop time is m analog slots plus n remote slots.
// - Fan monitoring starts with the loop and runs unsynchronised.
package mon_pkg;
   // Timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int T_ANALOG_NS = 6044000;
   localparam int T_REMOTE_NS = 33240000;
   localparam int SLOT_ANALOG_CYC = T_ANALOG_NS / CLK_PERIOD_NS;
   localparam int SLOT_REMOTE_CYC = T_REMOTE_NS / CLK_PERIOD_NS;
   localparam int TIMER_W = 24;
   localparam logic [3:0] AVG_LAST = 4'hf;
   // Channels
   localparam int NUM_CH = 10;
   localparam logic [3:0] LAST_CH = 4'h9;
   localparam logic [3:0] LOCAL_CH = 4'h7;
   localparam logic [3:0] REMOTE1_CH = 4'h8;
   localparam logic [3:0] SHARED_CH = 4'h9;
   // Register indices, byte address is four times the index
   localparam logic [7:0] IDX_VALUE_BASE = 8'h20;
   localparam logic [7:0] IDX_LOCAL_TEMP = 8'h27;
   localparam logic [7:0] IDX_CONFIG = 8'h40;
   localparam logic [7:0] IDX_STATUS_LO = 8'h41;
   localparam logic [7:0] IDX_STATUS_HI = 8'h42;
   localparam logic [7:0] IDX_CHAN_MODE = 8'h47;
   localparam logic [7:0] IDX_TEMP_CFG = 8'h4b;
   localparam logic [7:0] IDX_LIM_HIGH_BASE = 8'h50;
   localparam logic [7:0] IDX_LIM_LOW_BASE = 8'h60;
   // Field positions
   localparam int CFG_START_BIT = 0;
   localparam int CFG_INTEN_BIT = 1;
   localparam int CFG_INTCLR_BIT = 3;
   localparam int MODE_REMOTE2_BIT = 2;
   // Reset values
   localparam logic [5:0] TEMP_CFG_RST = 6'h00;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] VOLT_HIGH_RST = 8'hff;
   localparam logic [7:0] VOLT_LOW_RST = 8'h00;
   localparam logic [7:0] TEMP_HOT_RST = 8'h7f;
   localparam logic [7:0] TEMP_HYST_RST = 8'h80;
   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_CONV = 5'h02,
      S_WAIT = 5'h04,
      S_STORE = 5'h08,
      S_HOLD = 5'h10
   } seq_state_t;
endpackage

/* verilog/monitor_cycle_temp_sequencer.sv */
// Measurement loop sequencer with Wishbone registers and limit events.
// Assumes a converter on clk: convStart pulse, later convValid with data.
`timescale 1ns/100ps
module monitor_cycle_temp_sequencer #(
   parameter int SLOT_ANALOG_CYCLES = mon_pkg::SLOT_ANALOG_CYC,
   parameter int SLOT_REMOTE_CYCLES = mon_pkg::SLOT_REMOTE_CYC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic convStart,
   output logic [3:0] convChan,
   output logic convRemote,
   input wire logic convValid,
   input wire logic [9:0] convData,
   output logic intN,
   output logic fanRun
);
   import mon_pkg::*;

   mon_if link();
   value_mem uMem (.clk(clk), .reset_n(reset_n), .port(link.memSide));
   limit_check uChk (.port(link.chkSide));

   logic busy, next_busy, next_ack;
   logic [31:0] next_dat;
   logic [7:0] idx, readByte;
   logic hit, wrStrobe, cfgWrite, clearReq;
   logic run, next_run, intEn, next_intEn;
   logic [7:0] chanMode, next_chanMode;
   logic [5:0] tempCfg, next_tempCfg;
   logic [1:0] frac, next_frac;
   logic [NUM_CH-1:0] status, next_status, hot, next_hot;
   logic [7:0] limHigh [NUM_CH];
   logic [7:0] limLow [NUM_CH];
   seq_state_t state, next_state;
   logic [3:0] chan, next_chan, count, next_count;
   logic [TIMER_W-1:0] timer, next_timer;
   logic signed [11:0] acc, next_acc;
   logic [7:0] result, next_result;
   logic [1:0] resFrac, next_resFrac;
   logic next_convStart, next_convRemote, next_intN;
   logic shared, curRemote, curTemp;

   function automatic logic isRemote(input logic [3:0] ch, input logic sh);
      return ch == REMOTE1_CH || (ch == SHARED_CH && sh);
   endfunction

   function automatic logic [TIMER_W-1:0] slotLen(input logic remote);
      return remote ? TIMER_W'(SLOT_REMOTE_CYCLES - 1)
                    : TIMER_W'(SLOT_ANALOG_CYCLES - 1);
   endfunction

   // Bus decode, one word per register
   assign idx = wb_adr_i[9:2];
   assign hit = wb_adr_i[31:10] == 22'h0 && wb_adr_i[1:0] == 2'h0;
   assign wrStrobe = busy && wb_we_i && wb_sel_i[0] && hit;
   assign cfgWrite = wrStrobe && idx == IDX_CONFIG;
   assign clearReq = cfgWrite && wb_dat_i[CFG_INTCLR_BIT];
   assign link.rdAddr = idx[3:0];
   assign shared = chanMode[MODE_REMOTE2_BIT];
   assign curRemote = isRemote(chan, shared);
   assign curTemp = curRemote || chan == LOCAL_CH;

   // Read mux for the answer cycle
   always_comb begin
      readByte = 8'h00;
      if (hit) begin
         if (idx >= IDX_VALUE_BASE && idx <= IDX_VALUE_BASE + 8'(LAST_CH)) begin
            readByte = link.rdData;
         end else if (idx >= IDX_LIM_HIGH_BASE
                      && idx <= IDX_LIM_HIGH_BASE + 8'(LAST_CH)) begin
            readByte = limHigh[idx[3:0]];
         end else if (idx >= IDX_LIM_LOW_BASE
                      && idx <= IDX_LIM_LOW_BASE + 8'(LAST_CH)) begin
            readByte = limLow[idx[3:0]];
         end else if (idx == IDX_CONFIG) begin
            readByte = {6'h00, intEn, run};
         end else if (idx == IDX_STATUS_LO) begin
            readByte = status[7:0];
         end else if (idx == IDX_STATUS_HI) begin
            readByte = {6'h00, status[NUM_CH-1:8]};
         end else if (idx == IDX_CHAN_MODE) begin
            readByte = chanMode;
         end else if (idx == IDX_TEMP_CFG) begin
            readByte = {frac, tempCfg};
         end
      end
   end

   // Bus handshake: take, then answer one cycle later
   always_comb begin
      next_busy = busy;
      next_ack = 1'b0;
      next_dat = wb_dat_o;
      if (wb_cyc_i && wb_stb_i && !busy && !wb_ack_o) begin
         next_busy = 1'b1;
      end else if (busy) begin
         next_busy = 1'b0;
         next_ack = 1'b1;
         next_dat = wb_we_i ? 32'h0 : {24'h0, readByte};
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         busy <= next_busy;
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end

   // Limit registers, one pair per channel
   for (genvar g = 0; g < NUM_CH; g++) begin : gLim
      localparam logic TEMP_KIND = 4'(g) == LOCAL_CH || 4'(g) == REMOTE1_CH;
      logic [7:0] next_high, next_low;
      always_comb begin
         next_high = limHigh[g];
         next_low = limLow[g];
         if (wrStrobe && idx == IDX_LIM_HIGH_BASE + 8'(g)) begin
            next_high = wb_dat_i[7:0];
         end
         if (wrStrobe && idx == IDX_LIM_LOW_BASE + 8'(g)) begin
            next_low = wb_dat_i[7:0];
         end
      end
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            limHigh[g] <= TEMP_KIND ? TEMP_HOT_RST : VOLT_HIGH_RST;
            limLow[g] <= TEMP_KIND ? TEMP_HYST_RST : VOLT_LOW_RST;
         end else begin
            limHigh[g] <= next_high;
            limLow[g] <= next_low;
         end
      end
   end

   // Limit checker feed
   assign link.result = result;
   assign link.high = limHigh[chan];
   assign link.low = limLow[chan];
   assign link.isTemp = curTemp;
   assign link.hotIn = hot[chan];
   assign link.wrEn = state == S_STORE;
   assign link.wrAddr = chan;
   assign link.wrData = result;

   // Control and status registers
   always_comb begin
      next_run = run;
      next_intEn = intEn;
      next_chanMode = chanMode;
      next_tempCfg = tempCfg;
      next_frac = frac;
      next_hot = hot;
      next_status = clearReq ? '0 : status;
      if (cfgWrite) begin
         next_intEn = wb_dat_i[CFG_INTEN_BIT];
         if (!wb_dat_i[CFG_START_BIT]) begin
            next_run = 1'b0;
         end else if (!wb_dat_i[CFG_INTCLR_BIT]) begin
            next_run = 1'b1;
         end
      end
      if (wrStrobe && idx == IDX_CHAN_MODE) begin
         next_chanMode = wb_dat_i[7:0];
      end
      if (wrStrobe && idx == IDX_TEMP_CFG) begin
         next_tempCfg = wb_dat_i[5:0];
      end
      if (state == S_STORE) begin
         if (chan == LOCAL_CH) begin
            next_frac = resFrac;
         end
         if (curTemp) begin
            next_hot[chan] = link.hotOut;
            if (link.hotOut) begin
               next_status[chan] = 1'b1;
            end
         end else if (link.over || link.under) begin
            next_status[chan] = 1'b1;
         end
      end
      next_intN = !(next_intEn && |next_status);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         run <= 1'b0;
         intEn <= 1'b0;
         chanMode <= MODE_RST;
         tempCfg <= TEMP_CFG_RST;
         frac <= 2'h0;
         hot <= '0;
         status <= '0;
         intN <= 1'b1;
         fanRun <= 1'b0;
      end else begin
         run <= next_run;
         intEn <= next_intEn;
         chanMode <= next_chanMode;
         tempCfg <= next_tempCfg;
         frac <= next_frac;
         hot <= next_hot;
         status <= next_status;
         intN <= next_intN;
         fanRun <= next_run;
      end
   end

   // Round-robin sequencer
   always_comb begin
      next_state = state;
      next_chan = chan;
      next_count = count;
      next_acc = acc;
      next_result = result;
      next_resFrac = resFrac;
      next_convStart = 1'b0;
      next_timer = timer == '0 ? timer : timer - 1'b1;
      unique case (state)
         S_IDLE: begin
            if (run) begin
               next_state = S_CONV;
               next_chan = 4'h0;
               next_count = 4'h0;
               next_acc = '0;
               next_timer = slotLen(isRemote(4'h0, shared));
            end
         end
         S_CONV: begin
            next_convStart = 1'b1;
            next_state = S_WAIT;
         end
         S_WAIT: begin
            if (convValid) begin
               next_result = convData[9:2];
               next_resFrac = convData[1:0];
               if (curRemote) begin
                  next_acc = acc + {{4{convData[9]}}, convData[9:2]};
                  next_result = next_acc[11:4];
                  next_count = count + 4'h1;
                  next_state = count == AVG_LAST ? S_STORE : S_CONV;
               end else begin
                  next_state = S_STORE;
               end
            end
         end
         S_STORE: begin
            next_state = S_HOLD;
         end
         S_HOLD: begin
            if (timer == '0) begin
               next_chan = chan == LAST_CH ? 4'h0 : chan + 4'h1;
               next_count = 4'h0;
               next_acc = '0;
               next_timer = slotLen(isRemote(next_chan, shared));
               next_state = S_CONV;
            end
         end
      endcase
      if (!run) begin
         next_state = S_IDLE;
      end
      next_convRemote = isRemote(next_chan, shared);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= S_IDLE;
         chan <= 4'h0;
         count <= 4'h0;
         acc <= '0;
         result <= 8'h00;
         resFrac <= 2'h0;
         timer <= '0;
         convStart <= 1'b0;
         convChan <= 4'h0;
         convRemote <= 1'b0;
      end else begin
         state <= next_state;
         chan <= next_chan;
         count <= next_count;
         acc <= next_acc;
         result <= next_result;
         resFrac <= next_resFrac;
         timer <= next_timer;
         convStart <= next_convStart;
         convChan <= next_chan;
         convRemote <= next_convRemote;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   start_write_a: assert property (!run && cfgWrite && wb_dat_i[0]
      && !wb_dat_i[3] |=> run ##1 state == S_CONV)
      else $error("start write did not start loop");
   stop_write_a: assert property (cfgWrite && !wb_dat_i[0]
      |=> !run ##1 state == S_IDLE)
      else $error("stop write did not halt loop");
   int_pin_a: assert property (intN == !(intEn && |status))
      else $error("interrupt pin disagrees with status");
   volt_event_a: assert property (state == S_STORE && !curTemp
      && (link.over || link.under) |=> status[$past(chan)])
      else $error("voltage limit event lost");
   hot_hold_a: assert property (state == S_STORE && curTemp && hot[chan]
      && !link.under |=> hot[$past(chan)])
      else $error("hot state dropped above hysteresis");
   remote_avg_a: assert property (state == S_STORE && curRemote
      |-> $past(count) == AVG_LAST)
      else $error("remote stored before sixteen samples");
   store_prompt_a: assert property (state == S_WAIT && convValid && !curRemote
      && run |=> state == S_STORE)
      else $error("result not stored after conversion");
   local_frac_a: assert property (state == S_STORE && chan == LOCAL_CH
      |=> frac == $past(resFrac))
      else $error("fraction bits not updated");
   fan_start_a: assert property ($rose(run) |-> $rose(fanRun))
      else $error("fan loop not started with analog loop");

   loop_wrap_c: cover property (state == S_HOLD && chan == LAST_CH
      && timer == '0);
   remote_store_c: cover property (state == S_STORE && curRemote);
   int_fire_c: cover property ($fell(intN));
   int_clear_c: cover property (clearReq ##1 intN);
endmodule // monitor_cycle_temp_sequencer

/* verilog/value_mem.sv */
// Value store: one byte per channel, registered read port for the bus.
// Assumes writer and reader share clk; a read during a write sees old data.
`timescale 1ns/100ps
module value_mem (
   input wire logic clk,
   input wire logic reset_n,
   mon_if.memSide port
);
   import mon_pkg::*;
   logic [7:0] store [NUM_CH];
   logic [7:0] next_rdData;

   // Out-of-range reads return zero
   always_comb begin
      next_rdData = 8'h00;
      if (port.rdAddr <= LAST_CH) begin
         next_rdData = store[port.rdAddr];
      end
   end

   // Data array, no reset needed
   always_ff @(posedge clk) begin
      if (port.wrEn && port.wrAddr <= LAST_CH) begin
         store[port.wrAddr] <= port.wrData;
      end
   end

   // Read data register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         port.rdData <= 8'h00;
      end else begin
         port.rdData <= next_rdData;
      end
   end
endmodule // value_mem
